// [core/bioz_input_mux_config.sv]
// AHB-Lite register bank for the bioimpedance input mux and resistance self-test
// What this block does
// - read/write mux configuration register at 0x17
// - bit 21 isolates positive input, default 1
// - bit 20 isolates negative input, default 1
// - bits 19:18 positive input calibration source
// - bits 17:16 negative input calibration source
// - calibration voltage codes need calibration enable
// - bits 13:12 select current generator mode
// - bit 11 enables resistance self-test
// - self-test only while calibration voltage disabled
// - self-test opens drive, closes loopback, 200M bias
// - bits 10:8 select self-test nominal resistance
// - bits 6:4 modulated resistance, 1xx none
// - bits 1:0 divide master clock 2^13..2^19
// - modulation waveform has 50 percent duty
//
// Local design decision: the AHB-Lite slave port.
module bioz_input_mux_config (
	input  wire logic                        hclk,
	input  wire logic                        hresetn,
	input  wire logic                        hsel,
	input  wire logic [31:0]                 haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [31:0]                 hwdata,
	input  wire logic                        hready,
	output logic      [31:0]                 hrdata,
	output logic                             hreadyout,
	output logic                             hresp,
	output bioz_mux_pkg::analog_ctrl_t       analog_ctrl
);
	import bioz_mux_pkg::*;

	// -----------------------------------------------------------------
	// address phase capture
	// -----------------------------------------------------------------
	bus_state_t       state;
	bus_state_t       next_state;
	logic [9:0]       addr_q;
	logic             addr_take;
	logic [9:0]       addr_low;

	assign addr_low  = haddr[ADDR_MSB:ADDR_LSB];
	assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);

	always_comb begin
		next_state = BUS_IDLE;
		if (addr_take) begin
			next_state = hwrite ? BUS_WRITE : BUS_READ;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state  <= BUS_IDLE;
			addr_q <= '0;
		end else begin
			state  <= next_state;
			addr_q <= addr_take ? addr_low : addr_q;
		end
	end

	// -----------------------------------------------------------------
	// register decode
	// -----------------------------------------------------------------
	logic             wr_phase;
	logic             wr_mux_cfg;
	logic             wr_cal_ctrl;
	logic [23:0]      mux_cfg_word;
	logic [23:0]      cal_ctrl_word;
	mux_cfg_t         cfg;
	logic             cal_voltage_enable;

	assign wr_phase    = (state == BUS_WRITE);
	assign wr_mux_cfg  = wr_phase && (addr_q == MUX_CFG_ADDR);
	assign wr_cal_ctrl = wr_phase && (addr_q == CAL_CTRL_ADDR);

	// reserved bits are masked off here and so always read zero
	config_word #(
		.WIDTH  (REG_WIDTH),
		.RESET  (MUX_CFG_RESET),
		.WMASK  (MUX_CFG_WMASK)
	) u_mux_cfg (
		.hclk    (hclk),
		.hresetn (hresetn),
		.wr_en   (wr_mux_cfg),
		.wr_data (hwdata[REG_WIDTH-1:0]),
		.value   (mux_cfg_word)
	);

	// calibration voltage enable mirror, bit 0 of a local register
	config_word #(
		.WIDTH  (REG_WIDTH),
		.RESET  (24'h00_0000),
		.WMASK  (24'h00_0001)
	) u_cal_ctrl (
		.hclk    (hclk),
		.hresetn (hresetn),
		.wr_en   (wr_cal_ctrl),
		.wr_data (hwdata[REG_WIDTH-1:0]),
		.value   (cal_ctrl_word)
	);

	assign cal_voltage_enable = cal_ctrl_word[0];

	assign cfg.pos_input_isolate          = mux_cfg_word[POS_ISO_BIT];
	assign cfg.neg_input_isolate          = mux_cfg_word[NEG_ISO_BIT];
	assign cfg.pos_cal_source_sel         = mux_cfg_word[POS_CAL_LSB +: 2];
	assign cfg.neg_cal_source_sel         = mux_cfg_word[NEG_CAL_LSB +: 2];
	assign cfg.current_gen_mode           = mux_cfg_word[CG_MODE_LSB +: 2];
	assign cfg.resistance_selftest_enable = mux_cfg_word[BIST_EN_BIT];
	assign cfg.selftest_nominal_res_sel   = mux_cfg_word[RNOM_LSB +: 3];
	assign cfg.selftest_modulated_res_sel = mux_cfg_word[RMOD_LSB +: 3];
	assign cfg.selftest_freq_sel          = mux_cfg_word[FREQ_LSB +: 2];

	// -----------------------------------------------------------------
	// effective analog control
	// -----------------------------------------------------------------
	logic             selftest_active;
	logic [1:0]       pos_cal_eff;
	logic [1:0]       neg_cal_eff;
	logic             pos_is_vcal;
	logic             neg_is_vcal;
	logic [2:0]       mod_sw;
	logic             rmod_off;
	logic             mod_clk;
	analog_ctrl_t     next_analog;

	assign selftest_active = cfg.resistance_selftest_enable && !cal_voltage_enable;

	assign pos_is_vcal = (cfg.pos_cal_source_sel == CAL_VPOS) || (cfg.pos_cal_source_sel == CAL_VNEG);
	assign neg_is_vcal = (cfg.neg_cal_source_sel == CAL_VPOS) || (cfg.neg_cal_source_sel == CAL_VNEG);
	assign pos_cal_eff = (pos_is_vcal && !cal_voltage_enable) ? CAL_NONE : cfg.pos_cal_source_sel;
	assign neg_cal_eff = (neg_is_vcal && !cal_voltage_enable) ? CAL_NONE : cfg.neg_cal_source_sel;

	// 1xx and the reserved code leave every modulation switch open
	assign rmod_off = cfg.selftest_modulated_res_sel[RMOD_OFF_BIT]
		|| (cfg.selftest_modulated_res_sel == RMOD_RSVD);
	assign mod_sw   = (rmod_off || !selftest_active) ? 3'h0
		: (3'h1 << cfg.selftest_modulated_res_sel[1:0]);

	selftest_divider #(
		.WIDTH (DIV_WIDTH)
	) u_divider (
		.hclk     (hclk),
		.hresetn  (hresetn),
		.enable   (selftest_active),
		.freq_sel (cfg.selftest_freq_sel),
		.mod_clk  (mod_clk)
	);

	always_comb begin
		next_analog                      = '0;
		next_analog.pos_connect          = !cfg.pos_input_isolate;
		next_analog.neg_connect          = !cfg.neg_input_isolate;
		next_analog.pos_cal_apply        = pos_cal_eff;
		next_analog.neg_cal_apply        = neg_cal_eff;
		next_analog.current_gen_mode     = cfg.current_gen_mode;
		next_analog.selftest_active      = selftest_active;
		next_analog.drive_iso_open       = selftest_active;
		next_analog.drive_to_input_close = selftest_active;
		next_analog.lead_bias_200m       = selftest_active;
		next_analog.nominal_res_sel      = cfg.selftest_nominal_res_sel;
		next_analog.modulation_switches  = mod_sw;
		next_analog.modulation_clk       = mod_clk && selftest_active;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			analog_ctrl <= '0;
		end else begin
			analog_ctrl <= next_analog;
		end
	end

	// -----------------------------------------------------------------
	// read data and response
	// -----------------------------------------------------------------
	logic [31:0]      rd_value;
	logic [31:0]      status_word;
	logic [31:0]      next_hrdata;

	assign status_word = {29'h0000_0000, mod_clk, |mod_sw, selftest_active};
	assign rd_value    = (addr_low == MUX_CFG_ADDR)  ? {8'h00, mux_cfg_word}
		: (addr_low == CAL_CTRL_ADDR) ? {8'h00, cal_ctrl_word}
		: (addr_low == STATUS_ADDR)   ? status_word
		: 32'h0000_0000;
	assign next_hrdata = (addr_take && !hwrite) ? rd_value : 32'h0000_0000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hrdata    <= next_hrdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end
endmodule

// [core/config_word.sv]
// one stored configuration word with write mask and reset value
module config_word #(
	parameter int                WIDTH = bioz_mux_pkg::REG_WIDTH,
	parameter logic [WIDTH-1:0]  RESET = '0,
	parameter logic [WIDTH-1:0]  WMASK = '1
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             wr_en,
	input  wire logic [WIDTH-1:0] wr_data,
	output logic      [WIDTH-1:0] value
);
	logic [WIDTH-1:0] next_value;

	assign next_value = (wr_data & WMASK) | (value & ~WMASK);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			value <= RESET;
		end else if (wr_en) begin
			value <= next_value;
		end
	end
endmodule

// [core/selftest_divider.sv]
// divider giving a 50 percent duty modulation clock from the master clock
module selftest_divider #(
	parameter int WIDTH = bioz_mux_pkg::DIV_WIDTH
) (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       enable,
	input  wire logic [1:0] freq_sel,
	output logic            mod_clk
);
	import bioz_mux_pkg::*;

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic [WIDTH-1:0] half_last;
	logic             half_done;

	// half period = 2^(13+2*sel-1) clocks, so high and low halves match
	assign half_last  = WIDTH'((1 << (FREQ_BASE_EXP - 1 + FREQ_STEP_EXP * int'(freq_sel))) - 1);
	assign half_done  = (count >= half_last);
	assign next_count = half_done ? '0 : count + WIDTH'(1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count   <= '0;
			mod_clk <= 1'b0;
		end else if (!enable) begin
			count   <= '0;
			mod_clk <= 1'b0;
		end else begin
			count   <= next_count;
			mod_clk <= half_done ? ~mod_clk : mod_clk;
		end
	end
endmodule

// [dv/bioz_input_mux_config_tb.sv]
// self-checking bench for the mux configuration register block
module bioz_input_mux_config_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import bioz_mux_pkg::*;
	typedef struct packed {
		logic [31:0] a;
		logic [31:0] d;
		logic [31:0] r;
	} row_t;
	logic         hclk;
	logic         hresetn;
	logic         hsel;
	logic         hwrite;
	logic [1:0]   htrans;
	logic [2:0]   hsize;
	logic [31:0]  haddr;
	logic [31:0]  hwdata;
	logic [31:0]  hrdata;
	logic         hreadyout;
	logic         hresp;
	analog_ctrl_t actl;
	logic [31:0]  rd;
	logic [23:0]  mux;
	logic         cal;
	int           n;
	int           num_errors;
	int           cmp_count;
	// rows with the self-test bit set keep both inputs isolated
	row_t         rows [11] = '{
		'{32'h0000_005c, 32'hffff_ffff, 32'h003f_3f73},
		'{32'h0000_005c, 32'h0000_0000, 32'h0000_0000},
		'{32'h0000_005c, 32'h003a_1800, 32'h003a_1800},
		'{32'h0000_005c, 32'h0035_2a21, 32'h0035_2a21},
		// generator mode 11 only with no drive current in this bench
		'{32'h0000_005c, 32'h0030_3b31, 32'h0030_3b31},
		'{32'h0000_0080, 32'h0000_0001, 32'h0000_0001},
		'{32'h0000_005c, 32'h003e_0940, 32'h003e_0940},
		'{32'h0000_0080, 32'h0000_0000, 32'h0000_0000},
		// status: self-test just came on, no switch closed, clock still low
		'{32'h0000_0084, 32'hffff_ffff, 32'h0000_0001},
		'{32'h0000_0060, 32'hffff_ffff, 32'h0000_0000},
		'{32'h0000_005c, 32'h0000_0010, 32'h0000_0010}};
	bioz_input_mux_config uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .analog_ctrl(actl)
	);
	function automatic analog_ctrl_t exp_ctrl(input logic [23:0] m, input logic c);
		analog_ctrl_t e;
		logic         s;
		e = '0;
		s = m[11] & ~c;
		e.pos_connect = ~m[21];
		e.neg_connect = ~m[20];
		e.pos_cal_apply = (m[19] & ~c) ? 2'h0 : m[19:18];
		e.neg_cal_apply = (m[17] & ~c) ? 2'h0 : m[17:16];
		e.current_gen_mode = m[13:12];
		e.selftest_active = s;
		e.drive_iso_open = s;
		e.drive_to_input_close = s;
		e.lead_bias_200m = s;
		e.nominal_res_sel = m[10:8];
		e.modulation_switches = (s && m[6:4] < 3'h3) ? 3'b001 << m[5:4] : 3'h0;
		return e;
	endfunction
	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_ctrl(input analog_ctrl_t e);
		chk_word("analog_ctrl", 32'(e[18:1]), 32'(actl[18:1]));
	endtask
	task automatic complete_run();
		$display("errors %0d comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// one single transfer, waiting on hready in both phases
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int k;
		k = 0;
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		hsize <= HSIZE_WORD;
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 16);
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 32);
		r = hrdata;
		if (k >= 32) begin
			num_errors++;
			complete_run();
		end
	endtask
	task automatic wait_lvl(input logic v, output int c);
		c = 0;
		while (actl.modulation_clk === v && c < 20000) begin
			@(posedge hclk);
			#1 c++;
		end
		if (c >= 20000) begin
			num_errors++;
			complete_run();
		end
	endtask
	task automatic reset_check();
		hresetn <= 1'b0;
		repeat (16) @(posedge hclk);
		#1 chk_word("ctrl in reset", 32'h0000_0000, 32'(actl));
		@(posedge hclk);
		hresetn <= 1'b1;
		mux = 24'h30_0040;
		cal = 1'b0;
		xfer(1'b0, MUX_CFG_ADDR, 32'h0000_0000, rd);
		chk_word("reset value", 32'h0030_0040, rd);
		#1 chk_ctrl(exp_ctrl(mux, cal));
	endtask
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	initial begin
		{hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
		num_errors = 0;
		cmp_count = 0;
		reset_check();
		foreach (rows[i]) begin
			xfer(1'b1, rows[i].a, rows[i].d, rd);
			xfer(1'b0, rows[i].a, 32'h0000_0000, rd);
			chk_word("read back", rows[i].r, rd);
			if (rows[i].a == MUX_CFG_ADDR)
				mux = rows[i].r[23:0];
			if (rows[i].a == CAL_CTRL_ADDR)
				cal = rows[i].r[0];
			#1 chk_ctrl(exp_ctrl(mux, cal));
		end
		reset_check();
		for (int f = 0; f < 2; f++) begin
			xfer(1'b1, MUX_CFG_ADDR, 32'h0030_0800 | f, rd);
			wait_lvl(1'b0, n);
			wait_lvl(1'b1, n);
			chk_word("high half", 32'(1 << (12 + 2 * f)), 32'(n));
			wait_lvl(1'b0, n);
			chk_word("low half", 32'(1 << (12 + 2 * f)), 32'(n));
			xfer(1'b1, MUX_CFG_ADDR, 32'h0000_0000, rd);
		end
		complete_run();
	end
endmodule
bind bioz_input_mux_config bioz_mux_checker u_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .analog_ctrl(analog_ctrl)
);

// [dv/bioz_mux_checker_properties.sv]
// port-level assertions for the bioimpedance mux configuration block
module bioz_mux_checker
	import bioz_mux_pkg::*;
(
	input wire logic                       hclk,
	input wire logic                       hresetn,
	input wire logic                       hsel,
	input wire logic [31:0]                haddr,
	input wire logic [1:0]                 htrans,
	input wire logic                       hwrite,
	input wire logic [2:0]                 hsize,
	input wire logic [31:0]                hwdata,
	input wire logic                       hready,
	input wire logic [31:0]                hrdata,
	input wire logic                       hreadyout,
	input wire logic                       hresp,
	input wire bioz_mux_pkg::analog_ctrl_t analog_ctrl
);
	// ----------------
	// access tracking and modulation half-period counter
	// ----------------
	logic        wr_mux;
	logic        rd_mux;
	logic        mc_q;
	logic [18:0] run;
	logic [18:0] last;
	logic [1:0]  halves;
	wire         sa = analog_ctrl.selftest_active;
	wire         flip = analog_ctrl.modulation_clk != mc_q;
	wire         take = hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD
		&& haddr[9:0] == MUX_CFG_ADDR;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_mux <= 1'b0;
			rd_mux <= 1'b0;
			mc_q   <= 1'b0;
			run    <= '0;
			last   <= '0;
			halves <= '0;
		end else begin
			wr_mux <= take && hwrite;
			rd_mux <= take && !hwrite;
			mc_q   <= analog_ctrl.modulation_clk;
			if (!sa) begin
				run    <= '0;
				halves <= '0;
			end else if (flip) begin
				last   <= run;
				run    <= 19'h0_0001;
				halves <= (halves == 2'h3) ? halves : halves + 2'h1;
			end else begin
				run <= run + 19'h0_0001;
			end
		end
	end
	// ----------------
	// assertions
	// ----------------
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	pad_zero_a: assert property (rd_mux |-> (hrdata & 32'hffc0_c08c) == '0)
		else $error("unassigned bits read nonzero");
	iso_map_a: assert property (wr_mux |-> ##2
		analog_ctrl.pos_connect != $past(hwdata[21], 2)
		&& analog_ctrl.neg_connect != $past(hwdata[20], 2))
		else $error("isolation switches not following write");
	mode_nom_a: assert property (wr_mux |-> ##2
		analog_ctrl.current_gen_mode == $past(hwdata[13:12], 2)
		&& analog_ctrl.nominal_res_sel == $past(hwdata[10:8], 2))
		else $error("generator mode or nominal resistance wrong");
	bist_side_a: assert property ({analog_ctrl.drive_iso_open,
		analog_ctrl.drive_to_input_close, analog_ctrl.lead_bias_200m} == {3{sa}})
		else $error("self-test switch set wrong");
	cal_gate_a: assert property (sa |-> !analog_ctrl.pos_cal_apply[1]
		&& !analog_ctrl.neg_cal_apply[1])
		else $error("self-test active with calibration voltage applied");
	mod_sw_a: assert property ($onehot0(analog_ctrl.modulation_switches)
		&& (sa || analog_ctrl.modulation_switches == 3'h0))
		else $error("modulation switches wrong");
	clk_idle_a: assert property ((!sa) [*3] |-> !analog_ctrl.modulation_clk)
		else $error("modulation clock running while self-test off");
	half_len_a: assert property (sa && flip && halves != 2'h0 |-> run inside
		{19'h0_1000, 19'h0_4000, 19'h1_0000, 19'h4_0000})
		else $error("modulation half period wrong");
	duty_a: assert property (sa && flip && halves >= 2'h2 |-> run == last)
		else $error("modulation duty not even");
	cover property (wr_mux);
	cover property (rd_mux);
	cover property (sa && flip && halves == 2'h3);
endmodule

// [include/bioz_mux_pkg.sv]
// constants, field layout and types for the bioimpedance input mux configuration block
package bioz_mux_pkg;
	// -----------------------------------------------------------------
	// register map
	// -----------------------------------------------------------------
	localparam logic [7:0]  MUX_CFG_INDEX   = 8'h17;
	localparam logic [9:0]  MUX_CFG_ADDR    = {MUX_CFG_INDEX, 2'b00};
	localparam logic [9:0]  CAL_CTRL_ADDR   = 10'h080;
	localparam logic [9:0]  STATUS_ADDR     = 10'h084;
	localparam int          ADDR_LSB        = 0;
	localparam int          ADDR_MSB        = 9;

	// -----------------------------------------------------------------
	// field positions
	// -----------------------------------------------------------------
	localparam int POS_ISO_BIT   = 21;
	localparam int NEG_ISO_BIT   = 20;
	localparam int POS_CAL_LSB   = 18;
	localparam int NEG_CAL_LSB   = 16;
	localparam int CG_MODE_LSB   = 12;
	localparam int BIST_EN_BIT   = 11;
	localparam int RNOM_LSB      = 8;
	localparam int RMOD_LSB      = 4;
	localparam int FREQ_LSB      = 0;
	localparam int REG_WIDTH     = 24;

	localparam logic [23:0] MUX_CFG_WMASK = 24'h3f_3f73;
	localparam logic [23:0] MUX_CFG_RESET = 24'h30_0040;

	// -----------------------------------------------------------------
	// encodings
	// -----------------------------------------------------------------
	localparam logic [1:0] CAL_NONE   = 2'h0;
	localparam logic [1:0] CAL_MID    = 2'h1;
	localparam logic [1:0] CAL_VPOS   = 2'h2;
	localparam logic [1:0] CAL_VNEG   = 2'h3;
	localparam logic [2:0] RMOD_RSVD  = 3'h3;
	localparam int         RMOD_OFF_BIT = 2;

	// divider exponents 13,15,17,19; half period is 2^(exp-1) clocks
	localparam int FREQ_BASE_EXP = 13;
	localparam int FREQ_STEP_EXP = 2;
	localparam int DIV_WIDTH     = 19;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	// -----------------------------------------------------------------
	// types
	// -----------------------------------------------------------------
	typedef struct packed {
		logic       pos_input_isolate;
		logic       neg_input_isolate;
		logic [1:0] pos_cal_source_sel;
		logic [1:0] neg_cal_source_sel;
		logic [1:0] current_gen_mode;
		logic       resistance_selftest_enable;
		logic [2:0] selftest_nominal_res_sel;
		logic [2:0] selftest_modulated_res_sel;
		logic [1:0] selftest_freq_sel;
	} mux_cfg_t;

	typedef struct packed {
		logic       pos_connect;
		logic       neg_connect;
		logic [1:0] pos_cal_apply;
		logic [1:0] neg_cal_apply;
		logic [1:0] current_gen_mode;
		logic       selftest_active;
		logic       drive_iso_open;
		logic       drive_to_input_close;
		logic       lead_bias_200m;
		logic [2:0] nominal_res_sel;
		logic [2:0] modulation_switches;
		logic       modulation_clk;
	} analog_ctrl_t;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_WRITE,
		BUS_READ
	} bus_state_t;
endpackage
